// file: nvm_cfg_pkg.sv
// Constants, layouts and states shared by the configuration loader
package nvm_cfg_pkg;

  localparam int ADDR_W = 16;

  // Image word offsets
  localparam logic [15:0] W_INIT_CTRL1    = 16'h000a;
  localparam logic [15:0] W_FUNC_CTRL     = 16'h0049;
  localparam logic [15:0] W_FLASH_PARAM   = 16'h004a;
  localparam logic [15:0] W_BOOT_EXP_SIZE = 16'h004c;
  localparam logic [15:0] W_CLASS_LO      = 16'h004e;
  localparam logic [15:0] W_CLASS_HI      = 16'h004f;
  localparam int          BASE_EN_BIT     = 4;

  // Functions-control fields
  localparam int FC_REDIR_EN  = 15;
  localparam int FC_SERIAL_EN = 14;
  localparam int FC_KCS_EN    = 13;
  localparam int FC_REDIR_IRQ = 10;
  localparam int FC_SER_IRQ   = 8;
  localparam int FC_KCS_IRQ   = 6;

  // Flash-parameter fields
  localparam int FP_ERASE_LSB = 8;
  localparam int FP_BURST     = 5;
  localparam int FP_LONG      = 4;

  // Boot-expansion-size fields
  localparam int BE_KCS_ROM  = 15;
  localparam int BE_REDIR_ROM = 14;
  localparam int BE_LAN_ROM  = 13;
  localparam int BE_LAN_BAR  = 12;

  // Reset defaults
  localparam logic [2:0]  DEF_FUNC_STATE = 3'h0;
  localparam logic [1:0]  DEF_REDIR_IRQ  = 2'h1;
  localparam logic [1:0]  DEF_SER_IRQ    = 2'h2;
  localparam logic [1:0]  DEF_KCS_IRQ    = 2'h3;
  localparam logic [7:0]  DEF_ERASE_OP   = 8'hff;
  localparam logic [7:0]  ERASE_NONE     = 8'h00;
  localparam logic [3:0]  DEF_EXP_DIS    = 4'he;
  localparam logic [23:0] DEF_CLASS      = 24'h0c0701;
  localparam int          BURST_MAX_BYTES = 256;

  // ASF area
  localparam logic [7:0]  ASF_CRC_IDX  = 8'hb7;
  localparam logic [15:0] ASF_DEFAULT  = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_INIT     = 16'hffff;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CTRL = 5'h02,
    S_BASE = 5'h04,
    S_ASF  = 5'h08,
    S_DONE = 5'h10
  } load_state_t;

endpackage : nvm_cfg_pkg

// file: asf_crc16.sv
// Word-wide CRC accumulator for the ASF area
`timescale 1ns/1ps
`default_nettype none
module asf_crc16 (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_clr,
  input  wire logic        i_en,
  input  wire logic [15:0] i_word,
  output logic      [15:0] o_crc
);
  import nvm_cfg_pkg::*;

  // MSB-first, one word per enabled cycle
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int b = 15; b >= 0; b--) begin
      r = (r[15] ^ w[b]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  logic [15:0] crc_reg;
  wire  [15:0] crc_next = i_clr ? CRC_INIT : (i_en ? crc_step(crc_reg, i_word) : crc_reg);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) crc_reg <= CRC_INIT;
    else if (i_ce) crc_reg <= crc_next;
  end

  assign o_crc = crc_reg;
endmodule : asf_crc16
`default_nettype wire

// file: nvm_cfg_loader.sv
// Manageability configuration loader: base words and CRC-checked ASF area
`timescale 1ns/1ps
`default_nettype none
module nvm_cfg_loader #(
  parameter int ADDR_W = nvm_cfg_pkg::ADDR_W
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_CE,
  input  wire logic              I_LOAD_REQ,
  input  wire logic              I_ASF_MODE,
  input  wire logic              I_ASF_LOAD_REQ,
  input  wire logic [ADDR_W-1:0] I_ASF_AREA_BASE_POINTER,
  output logic                   O_RD_REQ,
  output logic      [ADDR_W-1:0] O_RD_ADDR,
  input  wire logic              I_RD_VALID,
  input  wire logic [15:0]       I_RD_DATA,
  output logic                   O_BUSY,
  output logic                   O_LOAD_DONE,
  output logic      [2:0]        O_FUNCTION_STATE_REGISTER,
  output logic                   O_REDIRECT_VISIBLE,
  output logic                   O_SERIAL_VISIBLE,
  output logic                   O_KCS_VISIBLE,
  output logic      [1:0]        O_REDIRECT_DISK_IRQ_PIN_SELECT,
  output logic      [1:0]        O_SERIAL_IRQ_PIN_SELECT,
  output logic      [1:0]        O_KBD_CTRL_STYLE_IRQ_PIN_SELECT,
  output logic      [7:0]        O_FLASH_CHIP_ERASE_OPCODE,
  output logic                   O_CHIP_ERASE_ALLOWED,
  output logic                   O_FLASH_BURST_WRITE_SELECT,
  output logic                   O_LONG_WRITE_CYCLE_SELECT,
  output logic                   O_WRITE_UNPROTECT_PULSE,
  output logic                   O_KCS_EXP_ROM_DIS,
  output logic                   O_REDIRECT_EXP_ROM_DIS,
  output logic                   O_LAN_EXP_ROM_DIS,
  output logic                   O_LAN_FLASH_BAR_DIS,
  output logic      [23:0]       O_KCS_CLASS_CODE,
  output logic                   O_ASF_LOADED,
  output logic                   O_ASF_CRC_ERR,
  input  wire logic [7:0]        I_ASF_RD_IDX,
  output logic      [15:0]       O_ASF_RD_DATA
);
  import nvm_cfg_pkg::*;

  function automatic logic is_word(input logic [ADDR_W-1:0] a, input logic [15:0] w);
    return a == ADDR_W'(w);
  endfunction : is_word

  load_state_t state_reg;
  load_state_t state_next;

  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic [7:0]        asf_idx_reg;
  logic              full_pend_reg;
  logic              asf_pend_reg;
  logic              powerup_reg;
  logic              done_reg;
  logic              unprot_reg;
  logic              bank_reg;
  logic              asf_loaded_reg;
  logic              crc_err_reg;
  logic [15:0]       asf_rd_reg;

  logic [2:0]  func_state_reg;
  logic [1:0]  redir_irq_reg;
  logic [1:0]  ser_irq_reg;
  logic [1:0]  kcs_irq_reg;
  logic [7:0]  erase_op_reg;
  logic        burst_reg;
  logic        long_reg;
  logic [3:0]  exp_dis_reg;
  logic [23:0] class_reg;

  // Two banks: the new image is written into the idle one and only a good CRC flips it in
  logic [15:0] asf_mem [0:511];

  wire [15:0] crc_val;

  // Handshake and decode
  wire got       = I_RD_VALID & O_RD_REQ;
  wire in_idle   = state_reg == S_IDLE;
  wire take_full = in_idle & full_pend_reg;
  wire take_asf  = in_idle & ~full_pend_reg & asf_pend_reg;
  wire ctrl_got  = got & (state_reg == S_CTRL);
  wire base_got  = got & (state_reg == S_BASE);
  wire asf_got   = got & (state_reg == S_ASF);
  wire asf_last  = asf_idx_reg == ASF_CRC_IDX;
  wire base_last = is_word(rd_addr_reg, W_CLASS_HI);
  wire crc_match = crc_val == I_RD_DATA;
  wire ld_func   = base_got & is_word(rd_addr_reg, W_FUNC_CTRL);
  wire ld_flash  = base_got & is_word(rd_addr_reg, W_FLASH_PARAM);
  wire ld_exp    = base_got & is_word(rd_addr_reg, W_BOOT_EXP_SIZE);
  wire ld_cls_lo = base_got & is_word(rd_addr_reg, W_CLASS_LO);
  wire ld_cls_hi = base_got & is_word(rd_addr_reg, W_CLASS_HI);
  wire asf_wr    = asf_got;
  wire [8:0] wr_idx = {~bank_reg, asf_idx_reg};
  wire [8:0] rd_idx = {bank_reg, I_ASF_RD_IDX};
  wire commit    = asf_got & asf_last & crc_match;
  wire crc_fail  = asf_got & asf_last & ~crc_match;

  // Next state
  always_comb begin
    state_next   = state_reg;
    rd_addr_next = rd_addr_reg;
    case (state_reg)
      S_IDLE: begin
        if (take_full) begin
          state_next   = S_CTRL;
          rd_addr_next = ADDR_W'(W_INIT_CTRL1);
        end else if (take_asf && I_ASF_MODE) begin
          state_next   = S_ASF;
          rd_addr_next = I_ASF_AREA_BASE_POINTER;
        end
      end
      S_CTRL: begin
        if (got && I_RD_DATA[BASE_EN_BIT]) begin
          state_next   = S_BASE;
          rd_addr_next = ADDR_W'(W_FUNC_CTRL);
        end else if (got && I_ASF_MODE) begin
          state_next   = S_ASF;
          rd_addr_next = I_ASF_AREA_BASE_POINTER;
        end else if (got) begin
          state_next   = S_DONE;
        end
      end
      S_BASE: begin
        if (got && !base_last) begin
          rd_addr_next = rd_addr_reg + ADDR_W'(1);
        end else if (got && I_ASF_MODE) begin
          state_next   = S_ASF;
          rd_addr_next = I_ASF_AREA_BASE_POINTER;
        end else if (got) begin
          state_next   = S_DONE;
        end
      end
      S_ASF: begin
        if (got && asf_last) begin
          state_next   = S_DONE;
        end else if (got) begin
          rd_addr_next = rd_addr_reg + ADDR_W'(1);
        end
      end
      S_DONE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg   <= S_IDLE;
      rd_addr_reg <= '0;
    end else if (I_CE) begin
      state_reg   <= state_next;
      rd_addr_reg <= rd_addr_next;
    end
  end

  // Sticky requests; a trigger in the cycle it is taken is kept
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      full_pend_reg <= 1'b1;
      asf_pend_reg  <= 1'b0;
    end else if (I_CE) begin
      full_pend_reg <= I_LOAD_REQ | (full_pend_reg & ~take_full);
      asf_pend_reg  <= I_ASF_LOAD_REQ | (asf_pend_reg & ~take_asf & ~take_full);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      asf_idx_reg <= '0;
    end else if (I_CE) begin
      if (state_next == S_ASF && state_reg != S_ASF) asf_idx_reg <= '0;
      else if (asf_got) asf_idx_reg <= asf_idx_reg + 8'h01;
    end
  end

  // Completion, power-up unprotect
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      done_reg    <= 1'b0;
      powerup_reg <= 1'b1;
      unprot_reg  <= 1'b0;
    end else if (I_CE) begin
      unprot_reg <= 1'b0;
      if (take_full) done_reg <= 1'b0;
      else if (state_reg == S_DONE) done_reg <= 1'b1;
      if (state_reg == S_DONE && powerup_reg) begin
        powerup_reg <= 1'b0;
        unprot_reg  <= ~burst_reg;
      end
    end
  end

  // Main-area fields used as read; reserved positions never sampled
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      func_state_reg <= DEF_FUNC_STATE;
      redir_irq_reg  <= DEF_REDIR_IRQ;
      ser_irq_reg    <= DEF_SER_IRQ;
      kcs_irq_reg    <= DEF_KCS_IRQ;
    end else if (I_CE && ld_func) begin
      func_state_reg <= {I_RD_DATA[FC_REDIR_EN], I_RD_DATA[FC_SERIAL_EN], I_RD_DATA[FC_KCS_EN]};
      redir_irq_reg  <= I_RD_DATA[FC_REDIR_IRQ +: 2];
      ser_irq_reg    <= I_RD_DATA[FC_SER_IRQ +: 2];
      kcs_irq_reg    <= I_RD_DATA[FC_KCS_IRQ +: 2];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      erase_op_reg <= DEF_ERASE_OP;
      burst_reg    <= 1'b0;
      long_reg     <= 1'b0;
    end else if (I_CE && ld_flash) begin
      erase_op_reg <= I_RD_DATA[FP_ERASE_LSB +: 8];
      burst_reg    <= I_RD_DATA[FP_BURST];
      long_reg     <= I_RD_DATA[FP_LONG];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      exp_dis_reg <= DEF_EXP_DIS;
    end else if (I_CE && ld_exp) begin
      exp_dis_reg <= {I_RD_DATA[BE_KCS_ROM], I_RD_DATA[BE_REDIR_ROM],
                      I_RD_DATA[BE_LAN_ROM], I_RD_DATA[BE_LAN_BAR]};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      class_reg <= DEF_CLASS;
    end else if (I_CE) begin
      if (ld_cls_lo) class_reg[15:0] <= I_RD_DATA;
      if (ld_cls_hi) class_reg[23:16] <= I_RD_DATA[7:0];
    end
  end

  // ASF staging and bank flip
  always_ff @(posedge I_CLK) begin
    if (I_CE && asf_wr) asf_mem[wr_idx] <= I_RD_DATA;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bank_reg       <= 1'b0;
      asf_loaded_reg <= 1'b0;
      crc_err_reg    <= 1'b0;
    end else if (I_CE) begin
      if (commit) begin
        bank_reg       <= ~bank_reg;
        asf_loaded_reg <= 1'b1;
        crc_err_reg    <= 1'b0;
      end else if (crc_fail) begin
        crc_err_reg <= 1'b1;
      end
    end
  end

  // Unloaded area reads as the erased value
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) asf_rd_reg <= ASF_DEFAULT;
    else if (I_CE) asf_rd_reg <= asf_loaded_reg ? asf_mem[rd_idx] : ASF_DEFAULT;
  end

  asf_crc16 u_crc (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_clr   (state_reg != S_ASF),
    .i_en    (asf_got & ~asf_last),
    .i_word  (I_RD_DATA),
    .o_crc   (crc_val)
  );

  // Outputs
  assign O_RD_REQ  = (state_reg == S_CTRL) | (state_reg == S_BASE) | (state_reg == S_ASF);
  assign O_RD_ADDR = rd_addr_reg;
  assign O_BUSY    = ~in_idle;
  assign O_LOAD_DONE = done_reg;
  assign O_FUNCTION_STATE_REGISTER = func_state_reg;
  // Functions stay hidden from the start of a full load until it finishes; ASF-only loads leave them visible
  assign O_REDIRECT_VISIBLE = func_state_reg[2] & done_reg;
  assign O_SERIAL_VISIBLE   = func_state_reg[1] & done_reg;
  assign O_KCS_VISIBLE      = func_state_reg[0] & done_reg;
  assign O_REDIRECT_DISK_IRQ_PIN_SELECT  = redir_irq_reg;
  assign O_SERIAL_IRQ_PIN_SELECT         = ser_irq_reg;
  assign O_KBD_CTRL_STYLE_IRQ_PIN_SELECT = kcs_irq_reg;
  assign O_FLASH_CHIP_ERASE_OPCODE  = erase_op_reg;
  assign O_CHIP_ERASE_ALLOWED       = erase_op_reg != ERASE_NONE;
  assign O_FLASH_BURST_WRITE_SELECT = burst_reg;
  assign O_LONG_WRITE_CYCLE_SELECT  = long_reg;
  assign O_WRITE_UNPROTECT_PULSE    = unprot_reg;
  assign O_KCS_EXP_ROM_DIS      = exp_dis_reg[3];
  assign O_REDIRECT_EXP_ROM_DIS = exp_dis_reg[2];
  assign O_LAN_EXP_ROM_DIS      = exp_dis_reg[1];
  assign O_LAN_FLASH_BAR_DIS    = exp_dis_reg[0];
  assign O_KCS_CLASS_CODE = class_reg;
  assign O_ASF_LOADED     = asf_loaded_reg;
  assign O_ASF_CRC_ERR    = crc_err_reg;
  assign O_ASF_RD_DATA    = asf_rd_reg;

endmodule : nvm_cfg_loader
`default_nettype wire

// file: nvm_cfg_loader_monitor.sv
// Port-level assertions for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module nvm_cfg_loader_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic              I_CE,
  input wire logic              I_ASF_MODE,
  input wire logic              O_RD_REQ,
  input wire logic [ADDR_W-1:0] O_RD_ADDR,
  input wire logic              I_RD_VALID,
  input wire logic [15:0]       I_RD_DATA,
  input wire logic [2:0]        O_FUNCTION_STATE_REGISTER,
  input wire logic [1:0]        O_REDIRECT_DISK_IRQ_PIN_SELECT,
  input wire logic [1:0]        O_SERIAL_IRQ_PIN_SELECT,
  input wire logic [1:0]        O_KBD_CTRL_STYLE_IRQ_PIN_SELECT,
  input wire logic [7:0]        O_FLASH_CHIP_ERASE_OPCODE,
  input wire logic              O_CHIP_ERASE_ALLOWED,
  input wire logic              O_FLASH_BURST_WRITE_SELECT,
  input wire logic              O_LONG_WRITE_CYCLE_SELECT,
  input wire logic              O_WRITE_UNPROTECT_PULSE,
  input wire logic [23:0]       O_KCS_CLASS_CODE
);
  import nvm_cfg_pkg::*;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  wire take = O_RD_REQ && I_RD_VALID && I_CE;
  property p_skip_base;
    take && O_RD_ADDR == W_INIT_CTRL1 && !I_RD_DATA[BASE_EN_BIT] && !I_ASF_MODE |=> !O_RD_REQ;
  endproperty
  a_skip_base: assert property (p_skip_base) else $error("base words fetched while off");
  property p_enter_base;
    take && O_RD_ADDR == W_INIT_CTRL1 && I_RD_DATA[BASE_EN_BIT] |=> O_RD_REQ && O_RD_ADDR == W_FUNC_CTRL;
  endproperty
  a_enter_base: assert property (p_enter_base) else $error("base words not fetched");
  property p_hold;
    O_RD_REQ && !(I_RD_VALID && I_CE) |=> O_RD_REQ && $stable(O_RD_ADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("read request dropped early");
  property p_func;
    take && O_RD_ADDR == W_FUNC_CTRL |=> O_FUNCTION_STATE_REGISTER == $past(I_RD_DATA[15:13]);
  endproperty
  a_func: assert property (p_func) else $error("function state wrong");
  property p_irq;
    take && O_RD_ADDR == W_FUNC_CTRL |=> {O_REDIRECT_DISK_IRQ_PIN_SELECT, O_SERIAL_IRQ_PIN_SELECT,
      O_KBD_CTRL_STYLE_IRQ_PIN_SELECT} == $past(I_RD_DATA[11:6]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pins wrong");
  property p_flash;
    take && O_RD_ADDR == W_FLASH_PARAM |=> {O_FLASH_CHIP_ERASE_OPCODE, O_FLASH_BURST_WRITE_SELECT,
      O_LONG_WRITE_CYCLE_SELECT} == {$past(I_RD_DATA[15:8]), $past(I_RD_DATA[5:4])};
  endproperty
  a_flash: assert property (p_flash) else $error("flash parameters wrong");
  property p_erase_ok;
    O_CHIP_ERASE_ALLOWED == (O_FLASH_CHIP_ERASE_OPCODE != ERASE_NONE);
  endproperty
  a_erase_ok: assert property (p_erase_ok) else $error("erase permission wrong");
  property p_unprot;
    O_WRITE_UNPROTECT_PULSE |-> !O_FLASH_BURST_WRITE_SELECT ##1 !O_WRITE_UNPROTECT_PULSE;
  endproperty
  a_unprot: assert property (p_unprot) else $error("unprotect pulse wrong");
  property p_class;
    take && O_RD_ADDR == W_CLASS_HI |=> O_KCS_CLASS_CODE == {$past(I_RD_DATA[7:0]), $past(O_KCS_CLASS_CODE[15:0])};
  endproperty
  a_class: assert property (p_class) else $error("class code wrong");
endmodule : nvm_cfg_loader_monitor
bind nvm_cfg_loader nvm_cfg_loader_monitor #(.ADDR_W(ADDR_W)) nvm_cfg_loader_monitor_inst (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_ASF_MODE(I_ASF_MODE), .O_RD_REQ(O_RD_REQ),
  .O_RD_ADDR(O_RD_ADDR), .I_RD_VALID(I_RD_VALID), .I_RD_DATA(I_RD_DATA),
  .O_FUNCTION_STATE_REGISTER(O_FUNCTION_STATE_REGISTER), .O_SERIAL_IRQ_PIN_SELECT(O_SERIAL_IRQ_PIN_SELECT),
  .O_REDIRECT_DISK_IRQ_PIN_SELECT(O_REDIRECT_DISK_IRQ_PIN_SELECT),
  .O_KBD_CTRL_STYLE_IRQ_PIN_SELECT(O_KBD_CTRL_STYLE_IRQ_PIN_SELECT),
  .O_FLASH_CHIP_ERASE_OPCODE(O_FLASH_CHIP_ERASE_OPCODE), .O_CHIP_ERASE_ALLOWED(O_CHIP_ERASE_ALLOWED),
  .O_FLASH_BURST_WRITE_SELECT(O_FLASH_BURST_WRITE_SELECT), .O_LONG_WRITE_CYCLE_SELECT(O_LONG_WRITE_CYCLE_SELECT),
  .O_WRITE_UNPROTECT_PULSE(O_WRITE_UNPROTECT_PULSE), .O_KCS_CLASS_CODE(O_KCS_CLASS_CODE));
`default_nettype wire

// file: nvm_image_model.sv
// Image memory model answering word reads after a variable wait
`timescale 1ns/1ps
`default_nettype none
module nvm_image_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [1:0]  i_wait,
  output var  logic        o_valid,
  output var  logic [15:0] o_data
);
  logic [15:0] mem [0:65535];
  logic [1:0]  wait_reg;
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 16'hffff;
    end
    mem[16'h0000] = 16'h1200;
    o_valid = 1'b0;
    o_data = 16'h0000;
    wait_reg = 2'h0;
  end
  // Idle data toggles so a late sample never matches by luck
  always @(posedge i_clk) begin
    if (!o_valid && i_req && wait_reg == 2'h0) begin
      o_valid <= 1'b1;
      o_data <= mem[i_addr];
      wait_reg <= i_wait;
    end else begin
      o_valid <= 1'b0;
      o_data <= ~o_data;
      if (i_req && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule : nvm_image_model
`default_nettype wire

// file: test_manageability_nvm_config_loader.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module test_manageability_nvm_config_loader;
  import nvm_cfg_pkg::*;
  logic        clk, rst_n, ce, lreq, amode, areq, rd_req, rd_vld, busy, done, unp, aload, aerr;
  logic        rv, sv, kv, allow, burst, lng, kdis, rdis, ldis, bdis;
  logic [1:0]  rirq, sirq, kirq, wt;
  logic [2:0]  fsr;
  logic [7:0]  op, idx;
  logic [15:0] base, rd_addr, rd_data, adata, fw, pw, bw, cl, ch;
  logic [23:0] cls;
  logic [15:0] img [0:183];
  logic [15:0] good [0:183];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          pulses = 0;
  nvm_cfg_loader nvm_cfg_loader_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_LOAD_REQ(lreq),
    .I_ASF_MODE(amode), .I_ASF_LOAD_REQ(areq), .I_ASF_AREA_BASE_POINTER(base), .O_RD_REQ(rd_req),
    .O_RD_ADDR(rd_addr), .I_RD_VALID(rd_vld), .I_RD_DATA(rd_data), .O_BUSY(busy), .O_LOAD_DONE(done),
    .O_FUNCTION_STATE_REGISTER(fsr), .O_REDIRECT_VISIBLE(rv), .O_SERIAL_VISIBLE(sv), .O_KCS_VISIBLE(kv),
    .O_REDIRECT_DISK_IRQ_PIN_SELECT(rirq), .O_SERIAL_IRQ_PIN_SELECT(sirq), .O_KBD_CTRL_STYLE_IRQ_PIN_SELECT(kirq),
    .O_FLASH_CHIP_ERASE_OPCODE(op), .O_CHIP_ERASE_ALLOWED(allow), .O_FLASH_BURST_WRITE_SELECT(burst),
    .O_LONG_WRITE_CYCLE_SELECT(lng), .O_WRITE_UNPROTECT_PULSE(unp), .O_KCS_EXP_ROM_DIS(kdis),
    .O_REDIRECT_EXP_ROM_DIS(rdis), .O_LAN_EXP_ROM_DIS(ldis), .O_LAN_FLASH_BAR_DIS(bdis), .O_KCS_CLASS_CODE(cls),
    .O_ASF_LOADED(aload), .O_ASF_CRC_ERR(aerr), .I_ASF_RD_IDX(idx), .O_ASF_RD_DATA(adata));
  nvm_image_model nvm_image_model_inst (.i_clk(clk), .i_req(rd_req), .i_addr(rd_addr), .i_wait(wt),
    .o_valid(rd_vld), .o_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    wt <= 2'($urandom_range(3, 0));
    if (unp === 1'b1) pulses++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_step
  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(n < 3000, 1);
  endtask : settle
  task automatic run(input logic full);
    lreq = full;
    areq = ~full;
    @(negedge clk);
    lreq = 1'b0;
    areq = 1'b0;
    repeat (3) @(negedge clk);
    settle();
  endtask : run
  task automatic check_fields(input logic [15:0] f, p, b, lo, hi);
    check(fsr, f[15:13]);
    check({rv, sv, kv, done}, {f[15:13], 1'b1});
    check({rirq, sirq, kirq}, f[11:6]);
    check({op, allow}, {p[15:8], p[15:8] != 8'h00});
    check({burst, lng}, p[5:4]);
    check({kdis, rdis, ldis, bdis}, b[15:12]);
    check(cls, {hi[7:0], lo});
  endtask : check_fields
  // Crc fix-up optional so a stale crc word can be left on purpose
  task automatic load_img(input logic fix);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 183; i++) begin
      c = crc_step(c, img[i]);
    end
    if (fix) img[183] = c;
    for (int i = 0; i < 184; i++) begin
      nvm_image_model_inst.mem[base + 16'(i)] = img[i];
    end
  endtask : load_img
  task automatic check_asf();
    // Starts on word 5, the one the first corrupt image flips
    for (int k = 5; k < 183; k += 44) begin
      idx = 8'(k);
      repeat (2) @(negedge clk);
      check(adata, good[k]);
    end
  endtask : check_asf
  initial begin
    void'($urandom(32'h4f2e));
    {lreq, areq, amode, idx, base, wt} = '0;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    // Written after time zero so the model's erase fill cannot overwrite it
    nvm_image_model_inst.mem[W_INIT_CTRL1] = 16'hffef;
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    settle();
    check_fields(16'h06c0, 16'hff00, 16'he000, 16'h0701, 16'h000c);
    check({done, aload, adata}, {2'b10, 16'hffff});
    for (int i = 0; i < 10; i++) begin
      {fw, pw, bw, cl, ch} = {$urandom, $urandom, 16'($urandom)};
      if (i == 0) pw[15:8] = 8'h00;
      if (i == 1) {fw, pw, bw} = '1;
      nvm_image_model_inst.mem[W_INIT_CTRL1] = 16'($urandom) | 16'h0010;
      nvm_image_model_inst.mem[W_FUNC_CTRL] = fw;
      nvm_image_model_inst.mem[W_FLASH_PARAM] = pw;
      nvm_image_model_inst.mem[W_BOOT_EXP_SIZE] = bw;
      nvm_image_model_inst.mem[W_CLASS_LO] = cl;
      nvm_image_model_inst.mem[W_CLASS_HI] = ch;
      run(1'b1);
      check_fields(fw, pw, bw, cl, ch);
    end
    base = 16'h0200 + 16'($urandom_range(255, 0));
    amode = 1'b1;
    for (int i = 0; i < 183; i++) begin
      img[i] = 16'($urandom);
    end
    load_img(1'b1);
    run(1'b0);
    good = img;
    check({aload, aerr}, 2'b10);
    check_asf();
    img[5] = ~img[5];
    load_img(1'b0);
    run(1'b0);
    check({aload, aerr}, 2'b11);
    check_asf();
    load_img(1'b1);
    run(1'b1);
    good = img;
    check({aload, aerr}, 2'b10);
    check_asf();
    amode = 1'b0;
    img[6] = ~img[6];
    load_img(1'b0);
    run(1'b0);
    check({aload, aerr}, 2'b10);
    check_asf();
    check(pulses, 1);
    summarize();
  end
endmodule : test_manageability_nvm_config_loader
`default_nettype wire
